// ===== ihc_top.sv
/*
 * Host controller of the infrared demo: program selection, vending
 * counters with a two-command interpreter, and the table streamer,
 * all talking to the protocol handler over a flow-controlled UART.
 * Assumes button and serial inputs are synchronous to clk.
 */
`timescale 1ns/10ps
module ihc_top #(
    parameter int TABLE_REPEAT = ihc_pkg::REPEAT_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       first_user_button,
    input  wire logic       second_user_button,
    input  wire logic       ser_rx,
    output logic            ser_tx,
    input  wire logic       cts_n,
    output logic      [7:0] soda_count,
    output logic      [7:0] candy_count,
    output logic            prog_vend,
    output logic            prog_xfer,
    output logic            method_burst,
    output logic            xfer_waiting,
    output logic            display_update
);
    import ihc_pkg::*;

    initial begin
        if (TABLE_REPEAT < 1 || TABLE_REPEAT > 255)
            $error("Table repeat count must be 1 to 255.");
        if (BIT_CYCLES >= 512)
            $error("Bit period does not fit the baud counters.");
    end

    localparam logic [8:0] BIT_LAST   = 9'(BIT_CYCLES - 1);
    localparam logic [8:0] HALF_LOAD  = 9'(HALF_BIT_CYCLES);
    localparam logic [7:0] TABLE_LAST = 8'(TABLE_LEN - 1);
    localparam logic [7:0] REP_LAST   = 8'(TABLE_REPEAT - 1);
    localparam logic [4:0] RPT_LAST   = 5'(REPORT_LEN - 1);
    localparam logic [6:0] BURST_LOAD = 7'(BURST_LEN);

    ////////////////////////////////////////////////////////////////////
    // Receiver.

    logic       rx_busy_q, rx_busy_d;
    logic [8:0] rx_cnt_q, rx_cnt_d;
    logic [3:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic       rx_valid_q, rx_valid_d;
    logic [7:0] rx_data_q, rx_data_d;

    // A start bit shorter than half a bit is taken as noise.
    always_comb begin
        rx_busy_d  = rx_busy_q;
        rx_cnt_d   = rx_cnt_q;
        rx_bit_d   = rx_bit_q;
        rx_sh_d    = rx_sh_q;
        rx_valid_d = 1'b0;
        rx_data_d  = rx_data_q;
        if (!rx_busy_q) begin
            if (!ser_rx) begin
                rx_busy_d = 1'b1;
                rx_cnt_d  = HALF_LOAD;
                rx_bit_d  = 4'h0;
            end
        end else if (rx_cnt_q != 9'h000) begin
            rx_cnt_d = rx_cnt_q - 9'h001;
        end else begin
            rx_cnt_d = BIT_LAST;
            if (rx_bit_q == 4'h0) begin
                rx_busy_d = !ser_rx;
                rx_bit_d  = 4'h1;
            end else if (rx_bit_q <= 4'h8) begin
                rx_sh_d  = {ser_rx, rx_sh_q[7:1]};
                rx_bit_d = rx_bit_q + 4'h1;
            end else begin
                rx_busy_d  = 1'b0;
                rx_valid_d = ser_rx;
                rx_data_d  = rx_sh_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_busy_q  <= 1'b0;
            rx_cnt_q   <= 9'h000;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_data_q  <= 8'h00;
        end else begin
            rx_busy_q  <= rx_busy_d;
            rx_cnt_q   <= rx_cnt_d;
            rx_bit_q   <= rx_bit_d;
            rx_sh_q    <= rx_sh_d;
            rx_valid_q <= rx_valid_d;
            rx_data_q  <= rx_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit buffer, flow control and transmitter.

    ihc_state_t state_q, state_d;
    logic       fifo_in_valid, fifo_in_ready, fifo_out_valid, tx_start;
    logic [7:0] fifo_in_data, fifo_out_data;
    logic       tx_busy_q, tx_busy_d, tx_line_q, tx_line_d;
    logic [8:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] tx_bit_q, tx_bit_d;
    logic [8:0] tx_sh_q, tx_sh_d;
    logic       cts_prev_q, burst_q, burst_d, burst_active, cts_fall, gate;
    logic [6:0] credit_q, credit_d;

    ihc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (tx_start),
        .out_data  (fifo_out_data)
    );

    assign burst_active = burst_q && (state_q == ST_XWAIT ||
                          state_q == ST_XSEND || state_q == ST_XDRAIN);
    assign cts_fall     = cts_prev_q && !cts_n;
    assign gate         = burst_active ? (credit_q != 7'h00)
                                       : !cts_n;
    assign tx_start     = !tx_busy_q && fifo_out_valid && gate;
    assign ser_tx       = tx_line_q;

    always_comb begin
        credit_d  = credit_q;
        tx_busy_d = tx_busy_q;
        tx_line_d = tx_line_q;
        tx_cnt_d  = tx_cnt_q;
        tx_bit_d  = tx_bit_q;
        tx_sh_d   = tx_sh_q;
        if (!burst_active)
            credit_d = 7'h00;
        else if (cts_fall)
            credit_d = BURST_LOAD;
        else if (tx_start)
            credit_d = credit_q - 7'h01;
        if (tx_start) begin
            tx_busy_d = 1'b1;
            tx_line_d = 1'b0;
            tx_sh_d   = {1'b1, fifo_out_data};
            tx_bit_d  = 4'h0;
            tx_cnt_d  = BIT_LAST;
        end else if (tx_busy_q) begin
            if (tx_cnt_q != 9'h000) begin
                tx_cnt_d = tx_cnt_q - 9'h001;
            end else if (tx_bit_q == 4'h9) begin
                tx_busy_d = 1'b0;
            end else begin
                tx_line_d = tx_sh_q[0];
                tx_sh_d   = {1'b1, tx_sh_q[8:1]};
                tx_bit_d  = tx_bit_q + 4'h1;
                tx_cnt_d  = BIT_LAST;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cts_prev_q <= 1'b0;
            credit_q   <= 7'h00;
            tx_busy_q  <= 1'b0;
            tx_line_q  <= 1'b1;
            tx_cnt_q   <= 9'h000;
            tx_bit_q   <= 4'h0;
            tx_sh_q    <= 9'h1ff;
        end else begin
            cts_prev_q <= cts_n;
            credit_q   <= credit_d;
            tx_busy_q  <= tx_busy_d;
            tx_line_q  <= tx_line_d;
            tx_cnt_q   <= tx_cnt_d;
            tx_bit_q   <= tx_bit_d;
            tx_sh_q    <= tx_sh_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Report text and table source.

    logic [7:0] idx_q, idx_d, rep_q, rep_d, rom_q;
    logic [7:0] soda_q, soda_d, candy_q, candy_d;
    logic [7:0] snap_s_q, snap_s_d, snap_c_q, snap_c_d;

    function automatic logic [7:0] digit(input logic [7:0] v,
                                         input logic [1:0] pos);
        logic [7:0] r;
        r = 8'h00;
        case (pos)
            2'h0:    r = v / 8'h64;
            2'h1:    r = (v / 8'h0a) % 8'h0a;
            default: r = v % 8'h0a;
        endcase
        return 8'h30 + r;
    endfunction

    function automatic logic [7:0] report_char(input logic [4:0] i,
                                               input logic [7:0] s,
                                               input logic [7:0] c);
        logic [7:0] ch;
        ch = 8'h20;
        case (i)
            5'd0:    ch = 8'h53;
            5'd1:    ch = 8'h6f;
            5'd2:    ch = 8'h64;
            5'd3:    ch = 8'h61;
            5'd5:    ch = 8'h3d;
            5'd7:    ch = digit(s, 2'h0);
            5'd8:    ch = digit(s, 2'h1);
            5'd9:    ch = digit(s, 2'h2);
            5'd10:   ch = 8'h0d;
            5'd11:   ch = 8'h0a;
            5'd12:   ch = 8'h43;
            5'd13:   ch = 8'h61;
            5'd14:   ch = 8'h6e;
            5'd15:   ch = 8'h64;
            5'd16:   ch = 8'h79;
            5'd18:   ch = 8'h3d;
            5'd20:   ch = digit(c, 2'h0);
            5'd21:   ch = digit(c, 2'h1);
            5'd22:   ch = digit(c, 2'h2);
            5'd23:   ch = 8'h0d;
            5'd24:   ch = 8'h0a;
            default: ch = 8'h20;
        endcase
        return ch;
    endfunction

    // The table address is the next index so the registered read
    // already holds the current byte when it is pushed.
    ihc_table_rom #(
        .LEN (TABLE_LEN)
    ) u_rom (
        .clk    (clk),
        .rst    (rst),
        .addr   (idx_d),
        .data_q (rom_q)
    );

    assign fifo_in_valid = (state_q == ST_REPORT) || (state_q == ST_XSEND);
    assign fifo_in_data  = (state_q == ST_XSEND) ? rom_q
                         : report_char(idx_q[4:0], snap_s_q, snap_c_q);

    ////////////////////////////////////////////////////////////////////
    // Program control.

    logic [1:0] btn_now, btn_prev_q, seen_q, seen_d;
    logic       press1, press2, upd_d;
    logic       pv_d, px_d, wait_d, pv_q, px_q, wait_q, upd_q;

    assign btn_now = {second_user_button, first_user_button};
    assign press1  = first_user_button && !btn_prev_q[0];
    assign press2  = second_user_button && !btn_prev_q[1];

    always_comb begin
        state_d  = state_q;
        seen_d   = seen_q;
        soda_d   = soda_q;
        candy_d  = candy_q;
        snap_s_d = snap_s_q;
        snap_c_d = snap_c_q;
        idx_d    = idx_q;
        rep_d    = rep_q;
        burst_d  = burst_q;
        upd_d    = 1'b0;
        if (state_q == ST_VEND || state_q == ST_REPORT) begin
            if (press1)
                soda_d = soda_q + 8'h01;
            if (press2)
                candy_d = candy_q + 8'h01;
            upd_d = press1 || press2;
        end
        case (state_q)
            ST_SELECT: begin
                seen_d = seen_q | btn_now;
                if (seen_q != 2'b00 && btn_now == 2'b00) begin
                    seen_d = 2'b00;
                    upd_d  = 1'b1;
                    if (seen_q == 2'b01)
                        state_d = ST_VEND;
                    else if (seen_q == 2'b11)
                        state_d = ST_METHOD;
                end
            end
            ST_VEND: begin
                if (rx_valid_q && rx_data_q == CMD_REPORT) begin
                    snap_s_d = soda_d;
                    snap_c_d = candy_d;
                    idx_d    = 8'h00;
                    state_d  = ST_REPORT;
                end else if (rx_valid_q && rx_data_q == CMD_CLEAR) begin
                    soda_d  = COUNT_RESET;
                    candy_d = COUNT_RESET;
                    upd_d   = 1'b1;
                end
            end
            ST_REPORT: begin
                if (fifo_in_ready) begin
                    idx_d = idx_q + 8'h01;
                    if (idx_q[4:0] == RPT_LAST) begin
                        idx_d   = 8'h00;
                        state_d = ST_VEND;
                    end
                end
            end
            ST_METHOD: begin
                if (press1 || press2) begin
                    burst_d = !press1;
                    state_d = ST_XWAIT;
                    upd_d   = 1'b1;
                end
            end
            ST_XWAIT: begin
                if (rx_valid_q) begin
                    idx_d   = 8'h00;
                    rep_d   = 8'h00;
                    state_d = ST_XSEND;
                    upd_d   = 1'b1;
                end
            end
            ST_XSEND: begin
                if (fifo_in_ready) begin
                    idx_d = idx_q + 8'h01;
                    if (idx_q == TABLE_LAST) begin
                        idx_d = 8'h00;
                        rep_d = rep_q + 8'h01;
                        if (rep_q == REP_LAST)
                            state_d = ST_XDRAIN;
                    end
                end
            end
            ST_XDRAIN: begin
                if (!fifo_out_valid && !tx_busy_q) begin
                    state_d = ST_METHOD;
                    upd_d   = 1'b1;
                end
            end
            default: state_d = ST_SELECT;
        endcase
        pv_d   = (state_d == ST_VEND || state_d == ST_REPORT);
        px_d   = !pv_d && state_d != ST_SELECT;
        wait_d = (state_d == ST_XWAIT);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_SELECT;
            btn_prev_q <= 2'b00;
            seen_q     <= 2'b00;
            soda_q     <= COUNT_RESET;
            candy_q    <= COUNT_RESET;
            snap_s_q   <= COUNT_RESET;
            snap_c_q   <= COUNT_RESET;
            idx_q      <= 8'h00;
            rep_q      <= 8'h00;
            burst_q    <= 1'b0;
            upd_q      <= 1'b0;
            pv_q       <= 1'b0;
            px_q       <= 1'b0;
            wait_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            btn_prev_q <= btn_now;
            seen_q     <= seen_d;
            soda_q     <= soda_d;
            candy_q    <= candy_d;
            snap_s_q   <= snap_s_d;
            snap_c_q   <= snap_c_d;
            idx_q      <= idx_d;
            rep_q      <= rep_d;
            burst_q    <= burst_d;
            upd_q      <= upd_d;
            pv_q       <= pv_d;
            px_q       <= px_d;
            wait_q     <= wait_d;
        end
    end

    assign soda_count     = soda_q;
    assign candy_count    = candy_q;
    assign prog_vend      = pv_q;
    assign prog_xfer      = px_q;
    assign method_burst   = burst_q;
    assign xfer_waiting   = wait_q;
    assign display_update = upd_q;

    ////////////////////////////////////////////////////////////////////
    // Checks.

    sel_vend_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == ST_VEND && $past(state_q) == ST_SELECT)
        |-> $past(seen_q) == 2'b01)
        else $error("Vending entered without the first button alone.");

    soda_inc_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == ST_VEND && press1 &&
         !(rx_valid_q && rx_data_q == CMD_CLEAR))
        |=> soda_q == $past(soda_q) + 8'h01)
        else $error("Soda counter did not advance on a press.");

    cmd_clear_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == ST_VEND && rx_valid_q && rx_data_q == CMD_CLEAR)
        |=> soda_q == 8'h00 && candy_q == 8'h00)
        else $error("Clear command left a counter nonzero.");

    cmd_report_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == ST_VEND && rx_valid_q && rx_data_q == CMD_REPORT)
        |=> state_q == ST_REPORT && fifo_in_data == 8'h53)
        else $error("Report command did not start the soda line.");

    cmd_ignore_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == ST_VEND && rx_valid_q && !press1 && !press2 &&
         rx_data_q != CMD_REPORT && rx_data_q != CMD_CLEAR)
        |=> state_q == ST_VEND && $stable(soda_q) && $stable(candy_q))
        else $error("Unknown byte changed the vending state.");

    level_gate_a: assert property (
        @(posedge clk) disable iff (rst)
        (!burst_active && cts_n && !tx_busy_q) |=> ser_tx)
        else $error("Byte started while CTS was high.");

    burst_load_a: assert property (
        @(posedge clk) disable iff (rst)
        (burst_active && cts_fall) |=> credit_q == 7'h40)
        else $error("Burst credit not loaded on CTS fall.");

    burst_gate_a: assert property (
        @(posedge clk) disable iff (rst)
        (burst_active && credit_q == 7'h00 && !tx_busy_q) |=> ser_tx)
        else $error("Burst byte sent without credit.");

    xfer_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == ST_XWAIT && !rx_valid_q) |=> state_q == ST_XWAIT)
        else $error("Transfer left waiting without a received byte.");

    xfer_back_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == ST_XDRAIN && !fifo_out_valid && !tx_busy_q)
        |=> state_q == ST_METHOD)
        else $error("Transfer did not return to method choice.");

endmodule // ihc_top

// ===== ihc_pkg.sv
/*
 * Shared constants and types of the infrared demo host controller.
 * Assumes a single 50 MHz clock and a UART link at 115,200 baud.
 */
package ihc_pkg;

    // Clock and serial link rates.
    localparam int CLK_HZ          = 50_000_000;
    localparam int BAUD_RATE       = 115_200;
    localparam int BIT_CYCLES      = CLK_HZ / BAUD_RATE;
    localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;

    // Vending command codes.
    localparam logic [7:0] CMD_REPORT = 8'h35;
    localparam logic [7:0] CMD_CLEAR  = 8'h36;

    // Transfer and report sizes.
    localparam int TABLE_LEN      = 250;
    localparam int BURST_LEN      = 64;
    localparam int REPEAT_DEFAULT = 1;
    localparam int REPORT_LEN     = 25;

    // Transmit buffer shape.
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // Reset values.
    localparam logic [7:0] COUNT_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_SELECT = 3'b000,
        ST_VEND   = 3'b001,
        ST_REPORT = 3'b010,
        ST_METHOD = 3'b011,
        ST_XWAIT  = 3'b100,
        ST_XSEND  = 3'b101,
        ST_XDRAIN = 3'b110
    } ihc_state_t;

endpackage

// ===== ihc_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; depth must be a power of two.
 */
`timescale 1ns/10ps
module ihc_fifo #(
    parameter int WIDTH = ihc_pkg::FIFO_WIDTH,
    parameter int DEPTH = ihc_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import ihc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("FIFO depth must be a power of two of at least 2.");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push)
            mem[wr_q] <= in_data;
    end

endmodule // ihc_fifo

// ===== ihc_table_rom.sv
/*
 * Constant transmit table with a registered read port.
 * Assumes the caller presents the next address so that data_q always
 * holds the byte of the current address.
 */
`timescale 1ns/10ps
module ihc_table_rom #(
    parameter int LEN = ihc_pkg::TABLE_LEN
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    output logic      [7:0] data_q
);
    import ihc_pkg::*;

    initial begin
        if (LEN < 1 || LEN > 256)
            $error("Table length must be 1 to 256.");
    end

    logic [7:0] data_d;

    // Printable stand-in pattern; replace the expression to load real data.
    always_comb begin
        data_d = 8'h21 + (addr % 8'h5e);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            data_q <= 8'h00;
        else
            data_q <= data_d;
    end

endmodule // ihc_table_rom

// ===== ihc_handler_model.sv
/* Model of the protocol handler: UART both ways and clear-to-send.
   Assumes the bench clock and the bit timing of ihc_pkg. */
`timescale 1ns/10ps
module ihc_handler_model
    import ihc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       ser_tx,
    input  wire logic       stall,
    input  wire logic       tx_go,
    input  wire logic [7:0] tx_data,
    output logic            ser_rx,
    output logic            cts_n,
    output logic            got_stb,
    output logic      [7:0] got_byte
);
    logic [9:0] frm;
    logic [8:0] sh;
    assign cts_n = stall;
    initial begin
        ser_rx = 1'b1;
        forever begin
            @(posedge clk);
            if (tx_go) begin
                frm = {1'b1, tx_data, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    @(negedge clk);
                    ser_rx = frm[i];
                    repeat (BIT_CYCLES - 1) @(negedge clk);
                end
            end
        end
    end
    // Sampling mid-bit leaves half a bit of slack for rate error.
    initial begin
        got_stb = 1'b0;
        got_byte = 8'h00;
        forever begin
            @(negedge ser_tx);
            repeat (HALF_BIT_CYCLES) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CYCLES) @(posedge clk);
                sh[i] = ser_tx;
            end
            if (sh[8]) begin
                got_byte <= sh[7:0];
                got_stb <= 1'b1;
                @(posedge clk);
                got_stb <= 1'b0;
            end
        end
    end
endmodule // ihc_handler_model

// ===== ir_demo_host_controller_tb.sv
/* Self-checking bench of the host controller with a handler model.
   Assumes the 50 MHz clock and a table repeat count of one. */
`timescale 1ns/10ps
module ir_demo_host_controller_tb;
    import ihc_pkg::*;
    typedef struct {logic f; logic s; logic [7:0] sd, cd;} ihc_row_t;
    logic       clk, rst, first_user_button, second_user_button, stall;
    logic       tx_go, got_stb, ser_rx, ser_tx, cts_n, prog_vend, prog_xfer;
    logic       method_burst, xfer_waiting, display_update;
    logic [7:0] tx_data, got_byte, soda_count, candy_count;
    logic [7:0] rx_q[$];
    int         error_cnt = 0, checks_done = 0, cyc = 0, upd_n = 0;
    ihc_row_t   rows[4] = '{'{1,0,1,0}, '{0,1,1,1}, '{0,1,1,2}, '{1,0,2,2}};
    string      rpt = "Soda = 001\r\n";
    ihc_top #(.TABLE_REPEAT(1)) uut (.clk(clk), .rst(rst),
        .first_user_button(first_user_button), .ser_rx(ser_rx),
        .second_user_button(second_user_button), .ser_tx(ser_tx),
        .cts_n(cts_n), .soda_count(soda_count), .candy_count(candy_count),
        .prog_vend(prog_vend), .prog_xfer(prog_xfer),
        .method_burst(method_burst), .xfer_waiting(xfer_waiting),
        .display_update(display_update));
    ihc_handler_model pm (.clk(clk), .ser_tx(ser_tx), .stall(stall),
        .tx_go(tx_go), .tx_data(tx_data), .ser_rx(ser_rx), .cts_n(cts_n),
        .got_stb(got_stb), .got_byte(got_byte));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (got_stb === 1'b1) rx_q.push_back(got_byte);
    always @(negedge clk) if (display_update === 1'b1) upd_n++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic final_report;
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic press(input logic f, input logic s);
        @(negedge clk);
        first_user_button = f;
        second_user_button = s;
        repeat (2) @(negedge clk);
        first_user_button = 1'b0;
        second_user_button = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic send(input logic [7:0] d);
        @(negedge clk);
        tx_go = 1'b1;
        tx_data = d;
        @(negedge clk);
        tx_go = 1'b0;
        repeat (10 * BIT_CYCLES) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {first_user_button, second_user_button, stall, tx_go} = 4'h0;
        tx_data = 8'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk1(ser_tx, 1'b1);
        chk1(prog_vend, 1'b0);
        press(1'b1, 1'b0);
        chk1(prog_vend, 1'b1);
        foreach (rows[i]) begin
            press(rows[i].f, rows[i].s);
            chk8(soda_count, rows[i].sd);
            chk8(candy_count, rows[i].cd);
        end
        chk8(8'(upd_n), 8'h05);
        send(8'h30);
        chk8(soda_count, 8'h02);
        chk8(8'(upd_n), 8'h05);
        chk1(rx_q.size() == 0, 1'b1);
        send(8'h36);
        chk8(soda_count, 8'h00);
        chk8(candy_count, 8'h00);
        press(1'b1, 1'b0);
        // Handler busy: the report must wait in the buffer.
        stall = 1'b1;
        send(8'h35);
        chk1(rx_q.size() == 0, 1'b1);
        stall = 1'b0;
        for (int w = 0; w < 60000 && rx_q.size() < 12; w++) @(negedge clk);
        for (int i = 0; i < 12; i++)
            chk8(rx_q[i], rpt[i]);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk1(ser_tx, 1'b1);
        chk8(soda_count, 8'h00);
        repeat (11 * BIT_CYCLES) @(negedge clk);
        rx_q.delete();
        press(1'b1, 1'b1);
        chk1(prog_xfer, 1'b1);
        press(1'b1, 1'b0);
        chk1(method_burst, 1'b0);
        chk1(xfer_waiting, 1'b1);
        chk1(rx_q.size() == 0, 1'b1);
        send(8'h41);
        chk1(xfer_waiting, 1'b0);
        for (int w = 0; w < 20000 && rx_q.size() < 3; w++) @(negedge clk);
        for (int i = 0; i < 3; i++)
            chk8(rx_q[i], 8'h21 + 8'(i));
        // Burst method: nothing may leave before a clear-to-send fall.
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        press(1'b1, 1'b1);
        press(1'b0, 1'b1);
        chk1(method_burst, 1'b1);
        send(8'h42);
        rx_q.delete();
        chk1(ser_tx, 1'b1);
        stall = 1'b1;
        @(negedge clk);
        stall = 1'b0;
        for (int w = 0; w < 6000 && rx_q.size() < 1; w++) @(negedge clk);
        chk8(rx_q[0], 8'h21);
        final_report();
    end
endmodule // ir_demo_host_controller_tb
